// ---- rtl/alc_defines.svh ----
// Register map, field positions, reset values and timing constants
`ifndef ALC_DEFINES_SVH
`define ALC_DEFINES_SVH

// ==========================================================
// Register offsets
`define ALC_ADDR_CTL 8'h2d
`define ALC_ADDR_MAIN_EN 8'h2e
`define ALC_ADDR_SECOND_EN 8'h2f
`define ALC_ADDR_MAIN_STAT 8'h30
`define ALC_ADDR_SECOND_STAT 8'h31

// ==========================================================
// Control register fields
`define ALC_SECOND_MAIN_SENSOR_FILTER_TIME_HI 7
`define ALC_SECOND_MAIN_SENSOR_FILTER_TIME_LO 5
`define ALC_SECOND_FORCE 4
`define ALC_MAIN_MAIN_SENSOR_FILTER_TIME_HI 3
`define ALC_MAIN_MAIN_SENSOR_FILTER_TIME_LO 1
`define ALC_MAIN_FORCE 0

// ==========================================================
// Reset values
`define ALC_MAIN_SENSOR_FILTER_TIME_RESET 3'h0
`define ALC_FORCE_RESET 2'h0
`define ALC_EN_RESET 4'h0
`define ALC_TRIP_RESET 4'h0
`define ALC_RD_RESET 8'h00
`define ALC_RSVD_ZERO 4'h0
`define ALC_TIMER_ZERO 32'h0000_0000
`define ALC_TIMER_ONE 32'h0000_0001

// ==========================================================
// Timing: shortest filter time and cycles per millisecond
`define ALC_MAIN_SENSOR_FILTER_TIME_BASE_MS 80
`define ALC_CYCLES_PER_MS 200000
`define ALC_MAIN_SENSOR_FILTER_TIME_BASE_CYCLES (`ALC_MAIN_SENSOR_FILTER_TIME_BASE_MS * `ALC_CYCLES_PER_MS)

// ==========================================================
// Level comparator geometry
`define ALC_LEVELS 4
`define ALC_CODE_W 8

`endif

// ---- rtl/alc_pkg.sv ----
// Types shared by the ambient light comparator control block
package alc_pkg;
  typedef logic [7:0] alc_byte_t;
  typedef logic [3:0] alc_level_t;
  typedef logic [2:0] alc_main_sensor_filter_time_t;
  typedef logic [31:0] alc_thr_t;
  // Gray coded conversion sequence
  typedef enum logic [1:0] {
    ALC_IDLE = 2'b00,
    ALC_REQ = 2'b01,
    ALC_WAIT = 2'b11,
    ALC_DONE = 2'b10
  } alc_conv_state_t;
endpackage

// ---- rtl/alc_level_cmp.sv ----
// Four level comparators of one sensor channel
`include "alc_defines.svh"
module alc_level_cmp (
  // Sensor sample and thresholds, level 2 in the low byte
  input wire alc_pkg::alc_byte_t sample,
  input wire alc_pkg::alc_thr_t thresholds,
  // Per-level enables, bit 0 is level 2
  input wire alc_pkg::alc_level_t levelEnable,
  // Comparator outputs
  output alc_pkg::alc_level_t levelTrip
);
  import alc_pkg::*;

  // ==========================================================
  // Comparators
  genvar k;
  generate
    for (k = 0; k < `ALC_LEVELS; k++) begin : g_lvl
      // Trip when photocurrent is below the threshold
      assign levelTrip[k] = levelEnable[k] &&
        (sample < thresholds[k*`ALC_CODE_W +: `ALC_CODE_W]);
    end
  endgenerate
endmodule // alc_level_cmp

// ---- rtl/alc_channel.sv ----
// Filter timer, conversion sequencer and status of one sensor channel
`include "alc_defines.svh"
module alc_channel #(
  parameter int unsigned BASE_CYCLES = `ALC_MAIN_SENSOR_FILTER_TIME_BASE_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Control
  input wire logic backlightOn,
  input wire alc_pkg::alc_main_sensor_filter_time_t filtCode,
  input wire logic forceReq,
  input wire alc_pkg::alc_level_t levelEnable,
  input wire alc_pkg::alc_thr_t thresholds,
  // Front end
  input wire alc_pkg::alc_byte_t sensorInput,
  input wire logic convDone,
  output logic convStart,
  // Status
  output logic convFinished,
  output logic busy,
  output alc_pkg::alc_level_t levelTrip
);
  import alc_pkg::*;

  alc_conv_state_t state_reg;
  alc_conv_state_t state_next;
  logic [31:0] timer_reg;
  logic [31:0] timerLimit;
  logic periodTick;
  logic startConv;
  alc_level_t cmpTrip;
  alc_level_t trip_reg;

  // ==========================================================
  // Filter timer, runs only while the backlight is on
  assign timerLimit = BASE_CYCLES << filtCode;
  assign periodTick = backlightOn &&
    (timer_reg == timerLimit - `ALC_TIMER_ONE);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_reg <= `ALC_TIMER_ZERO;
    end else if (!backlightOn || periodTick || timer_reg >= timerLimit) begin
      timer_reg <= `ALC_TIMER_ZERO;
    end else begin
      timer_reg <= timer_reg + `ALC_TIMER_ONE;
    end
  end

  a_tick_wrap: assert property (@(posedge mclk) disable iff (sys_rst)
    periodTick |=> timer_reg == `ALC_TIMER_ZERO)
    else $error("filter timer did not restart after period");

  // ==========================================================
  // Conversion sequencer
  assign startConv = backlightOn ? periodTick : forceReq;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ALC_IDLE: begin
        if (startConv) begin
          state_next = ALC_REQ;
        end
      end
      ALC_REQ: state_next = ALC_WAIT;
      ALC_WAIT: begin
        if (convDone) begin
          state_next = ALC_DONE;
        end
      end
      ALC_DONE: state_next = ALC_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ALC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign convStart = (state_reg == ALC_REQ);
  assign convFinished = (state_reg == ALC_DONE);
  assign busy = (state_reg != ALC_IDLE);

  // ==========================================================
  // Comparators and captured trip status
  alc_level_cmp u_cmp (
    .sample(sensorInput),
    .thresholds(thresholds),
    .levelEnable(levelEnable),
    .levelTrip(cmpTrip)
  );

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      trip_reg <= `ALC_TRIP_RESET;
    end else if (state_reg == ALC_WAIT && convDone) begin
      trip_reg <= cmpTrip;
    end else begin
      // A disabled level stops reporting on the next clock edge
      trip_reg <= trip_reg & levelEnable;
    end
  end

  assign levelTrip = trip_reg;

  a_trip_level: assert property (@(posedge mclk) disable iff (sys_rst)
    (state_reg == ALC_WAIT && convDone && levelEnable[0] &&
     sensorInput < thresholds[7:0]) |=> levelTrip[0])
    else $error("level 2 did not trip below threshold");
endmodule // alc_channel

// ---- rtl/alc_top.sv ----
// Control and status of the two ambient light comparator channels
`include "alc_defines.svh"

module alc_top #(
  parameter int unsigned MAIN_SENSOR_FILTER_TIME_BASE_CYCLES = `ALC_MAIN_SENSOR_FILTER_TIME_BASE_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register port from the serial host interface
  input wire alc_pkg::alc_byte_t regAddr,
  input wire alc_pkg::alc_byte_t regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output alc_pkg::alc_byte_t regRdData,
  // Backlight state
  input wire logic backlightOn,
  // Main sensor front end
  input wire alc_pkg::alc_byte_t mainSensorInput,
  input wire alc_pkg::alc_thr_t mainThresholds,
  input wire logic mainConvDone,
  output logic mainConvStart,
  // Second sensor front end
  input wire alc_pkg::alc_byte_t secondSensorInput,
  input wire alc_pkg::alc_thr_t secondThresholds,
  input wire logic secondConvDone,
  output logic secondConvStart,
  // Level outputs to the brightness logic
  output alc_pkg::alc_level_t mainLevelTrip,
  output alc_pkg::alc_level_t secondLevelTrip,
  output alc_pkg::alc_level_t secondAutoLevelEnable
);
  import alc_pkg::*;

  // ==========================================================
  // Register decode
  localparam int SEL_CTL = 0;
  localparam int SEL_MAIN_EN = 1;
  localparam int SEL_SECOND_EN = 2;
  localparam int SEL_MAIN_STAT = 3;
  localparam int SEL_SECOND_STAT = 4;

  function automatic logic [4:0] decodeReg(input alc_byte_t addr);
    logic [4:0] sel;
    sel = 5'h00;
    sel[SEL_CTL] = (addr == `ALC_ADDR_CTL);
    sel[SEL_MAIN_EN] = (addr == `ALC_ADDR_MAIN_EN);
    sel[SEL_SECOND_EN] = (addr == `ALC_ADDR_SECOND_EN);
    sel[SEL_MAIN_STAT] = (addr == `ALC_ADDR_MAIN_STAT);
    sel[SEL_SECOND_STAT] = (addr == `ALC_ADDR_SECOND_STAT);
    return sel;
  endfunction

  logic [4:0] wrSel;
  logic [4:0] rdSel;
  logic ctlWr;

  assign wrSel = regWrEn ? decodeReg(regAddr) : 5'h00;
  assign rdSel = regRdEn ? decodeReg(regAddr) : 5'h00;
  assign ctlWr = wrSel[SEL_CTL];

  // ==========================================================
  // Per-channel arrays: index 0 is main, 1 is second
  alc_main_sensor_filter_time_t main_sensor_filter_time_reg [2];
  logic [1:0] force_reg;
  logic [1:0] force_next;
  logic [1:0] forceSet;
  alc_level_t en_reg [2];
  logic [1:0] writtenForce;
  logic [1:0] convFinished;
  logic [1:0] busy;
  logic [1:0] convStart;
  logic [1:0] convDone;
  alc_level_t trip [2];
  alc_byte_t sensorIn [2];
  alc_thr_t thr [2];
  alc_main_sensor_filter_time_t writtenFilt [2];

  assign writtenForce[0] = regWrData[`ALC_MAIN_FORCE];
  assign writtenForce[1] = regWrData[`ALC_SECOND_FORCE];
  assign writtenFilt[0] =
    regWrData[`ALC_MAIN_MAIN_SENSOR_FILTER_TIME_HI:`ALC_MAIN_MAIN_SENSOR_FILTER_TIME_LO];
  assign writtenFilt[1] =
    regWrData[`ALC_SECOND_MAIN_SENSOR_FILTER_TIME_HI:`ALC_SECOND_MAIN_SENSOR_FILTER_TIME_LO];
  assign sensorIn[0] = mainSensorInput;
  assign sensorIn[1] = secondSensorInput;
  assign thr[0] = mainThresholds;
  assign thr[1] = secondThresholds;
  assign convDone[0] = mainConvDone;
  assign convDone[1] = secondConvDone;

  // ==========================================================
  // Filter time fields
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      main_sensor_filter_time_reg[0] <= `ALC_MAIN_SENSOR_FILTER_TIME_RESET;
      main_sensor_filter_time_reg[1] <= `ALC_MAIN_SENSOR_FILTER_TIME_RESET;
    end else if (ctlWr) begin
      main_sensor_filter_time_reg[0] <= writtenFilt[0];
      main_sensor_filter_time_reg[1] <= writtenFilt[1];
    end
  end

  // ==========================================================
  // Forced conversion requests
  // A set arriving with the finish of the previous conversion wins
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_force
      assign forceSet[c] = ctlWr && writtenForce[c];
      always_comb begin
        if (backlightOn) begin
          force_next[c] = 1'b0;
        end else if (forceSet[c]) begin
          force_next[c] = 1'b1;
        end else if (convFinished[c]) begin
          force_next[c] = 1'b0;
        end else begin
          force_next[c] = force_reg[c];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      force_reg <= `ALC_FORCE_RESET;
    end else begin
      force_reg <= force_next;
    end
  end

  // ==========================================================
  // Level enables, reserved upper bits are not stored
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      en_reg[0] <= `ALC_EN_RESET;
      en_reg[1] <= `ALC_EN_RESET;
    end else begin
      if (wrSel[SEL_MAIN_EN]) begin
        en_reg[0] <= regWrData[3:0];
      end
      if (wrSel[SEL_SECOND_EN]) begin
        en_reg[1] <= regWrData[3:0];
      end
    end
  end

  assign secondAutoLevelEnable = en_reg[1];

  // ==========================================================
  // Sensor channels
  generate
    for (c = 0; c < 2; c++) begin : g_chan
      alc_channel #(
        .BASE_CYCLES(MAIN_SENSOR_FILTER_TIME_BASE_CYCLES)
      ) u_chan (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .backlightOn(backlightOn),
        .filtCode(main_sensor_filter_time_reg[c]),
        .forceReq(force_reg[c]),
        .levelEnable(en_reg[c]),
        .thresholds(thr[c]),
        .sensorInput(sensorIn[c]),
        .convDone(convDone[c]),
        .convStart(convStart[c]),
        .convFinished(convFinished[c]),
        .busy(busy[c]),
        .levelTrip(trip[c])
      );
    end
  endgenerate

  assign mainConvStart = convStart[0];
  assign secondConvStart = convStart[1];
  assign mainLevelTrip = trip[0];
  assign secondLevelTrip = trip[1];

  // ==========================================================
  // Read data, registered; unmapped offsets read zero
  alc_byte_t rdValue;

  always_comb begin
    rdValue = `ALC_RD_RESET;
    unique case (1'b1)
      rdSel[SEL_CTL]: begin
        rdValue[`ALC_SECOND_MAIN_SENSOR_FILTER_TIME_HI:`ALC_SECOND_MAIN_SENSOR_FILTER_TIME_LO] = main_sensor_filter_time_reg[1];
        rdValue[`ALC_SECOND_FORCE] = force_reg[1];
        rdValue[`ALC_MAIN_MAIN_SENSOR_FILTER_TIME_HI:`ALC_MAIN_MAIN_SENSOR_FILTER_TIME_LO] = main_sensor_filter_time_reg[0];
        rdValue[`ALC_MAIN_FORCE] = force_reg[0];
      end
      rdSel[SEL_MAIN_EN]: rdValue = {`ALC_RSVD_ZERO, en_reg[0]};
      rdSel[SEL_SECOND_EN]: rdValue = {`ALC_RSVD_ZERO, en_reg[1]};
      rdSel[SEL_MAIN_STAT]: rdValue = {`ALC_RSVD_ZERO, trip[0]};
      rdSel[SEL_SECOND_STAT]: rdValue = {`ALC_RSVD_ZERO, trip[1]};
      default: rdValue = `ALC_RD_RESET;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= `ALC_RD_RESET;
    end else if (regRdEn) begin
      regRdData <= rdValue;
    end
  end

  // ==========================================================
  // Checks
  a_force_ignored: assert property (@(posedge mclk) disable iff (sys_rst)
    backlightOn |=> force_reg == 2'b00)
    else $error("forced conversion kept while backlight on");

  a_force_sets: assert property (@(posedge mclk) disable iff (sys_rst)
    (ctlWr && regWrData[`ALC_MAIN_FORCE] && !backlightOn)
      |=> force_reg[0])
    else $error("main forced conversion request not taken");

  a_force_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    (convFinished[1] && !forceSet[1]) |=> !force_reg[1])
    else $error("second forced conversion bit did not clear");

  a_conv_start: assert property (@(posedge mclk) disable iff (sys_rst)
    (force_reg[1] && !backlightOn && !busy[1] && !backlightOn)
      |=> secondConvStart)
    else $error("second forced conversion did not start");

  a_status_read: assert property (@(posedge mclk) disable iff (sys_rst)
    (regRdEn && regAddr == `ALC_ADDR_MAIN_STAT)
      |=> regRdData == {`ALC_RSVD_ZERO, $past(mainLevelTrip)})
    else $error("main status read mismatch");

  a_stat2_read: assert property (@(posedge mclk) disable iff (sys_rst)
    (regRdEn && regAddr == `ALC_ADDR_SECOND_STAT)
      |=> regRdData == {`ALC_RSVD_ZERO, $past(secondLevelTrip)})
    else $error("second status read mismatch");

  a_reserved_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    (regRdEn && (rdSel[SEL_MAIN_EN] || rdSel[SEL_SECOND_EN]))
      |=> regRdData[7:4] == `ALC_RSVD_ZERO)
    else $error("reserved enable bits not zero");

  a_trip_disabled: assert property (@(posedge mclk) disable iff (sys_rst)
    (en_reg[0] == `ALC_EN_RESET) [*2] |-> mainLevelTrip == 4'h0)
    else $error("disabled main level still trips");
endmodule // alc_top

// ---- testbench/alc_front_end_model.sv ----
// Behavioural phototransistor front end answering conversion requests
module alc_front_end_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Request from the channel
  input wire logic convStart,
  // Test controls: light code to report and answer delay
  input wire alc_pkg::alc_byte_t lightCode,
  input wire logic [3:0] latency,
  // Answer to the channel
  output alc_pkg::alc_byte_t sensorInput,
  output logic convDone
);
  timeunit 1ns;
  timeprecision 100ps;
  import alc_pkg::*;
  logic active;
  logic [3:0] countReg;

  // ==========================================================
  // Conversion timing
  // Outside the done cycle the code toggles, so stale sampling shows up
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      active <= 1'b0;
      countReg <= 4'h0;
      convDone <= 1'b0;
      sensorInput <= 8'h00;
    end else begin
      convDone <= 1'b0;
      sensorInput <= ~sensorInput;
      if (convStart) begin
        active <= 1'b1;
        countReg <= latency;
      end else if (active && countReg == 4'h0) begin
        active <= 1'b0;
        convDone <= 1'b1;
        sensorInput <= lightCode;
      end else if (active) begin
        countReg <= countReg - 4'h1;
      end
    end
  end
endmodule // alc_front_end_model

// ---- testbench/alc_top_tb.sv ----
// Self-checking testbench of the comparator control block
`include "alc_defines.svh"
module alc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import alc_pkg::*;
  localparam int unsigned BASE = 20;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  alc_byte_t regAddr = 8'h00;
  alc_byte_t regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  alc_byte_t regRdData;
  logic backlightOn = 1'b0;
  alc_thr_t mainThresholds = 32'h4030_2010;
  alc_thr_t secondThresholds = 32'h4030_2010;
  alc_byte_t mainSensorInput, secondSensorInput;
  logic mainConvDone, secondConvDone, mainConvStart, secondConvStart;
  alc_level_t mainLevelTrip, secondLevelTrip, secondAutoLevelEnable;
  int numErrors = 0;
  int nTests = 0;

  always #2.5 mclk = ~mclk;

  alc_top #(.MAIN_SENSOR_FILTER_TIME_BASE_CYCLES(BASE)) uut (
    .mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .backlightOn(backlightOn),
    .mainSensorInput(mainSensorInput), .mainThresholds(mainThresholds),
    .mainConvDone(mainConvDone), .mainConvStart(mainConvStart),
    .secondSensorInput(secondSensorInput),
    .secondThresholds(secondThresholds), .secondConvDone(secondConvDone),
    .secondConvStart(secondConvStart), .mainLevelTrip(mainLevelTrip),
    .secondLevelTrip(secondLevelTrip),
    .secondAutoLevelEnable(secondAutoLevelEnable)
  );

  // Main channel answers quickly, second channel slowly
  alc_front_end_model mainFe (
    .mclk(mclk), .sys_rst(sys_rst), .convStart(mainConvStart),
    .lightCode(8'h25), .latency(4'h1), .sensorInput(mainSensorInput),
    .convDone(mainConvDone)
  );
  alc_front_end_model secondFe (
    .mclk(mclk), .sys_rst(sys_rst), .convStart(secondConvStart),
    .lightCode(8'h05), .latency(4'ha), .sensorInput(secondSensorInput),
    .convDone(secondConvDone)
  );

  // ==========================================================
  // Register access tasks
  task automatic regWrite(input alc_byte_t a, input alc_byte_t d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge mclk);
    regWrEn <= 1'b0;
  endtask

  task automatic regRead(input alc_byte_t a, output alc_byte_t d);
    @(posedge mclk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge mclk);
    regRdEn <= 1'b0;
    #1;
    d = regRdData;
  endtask

  task automatic rdCheck(input alc_byte_t a, input alc_byte_t exp);
    alc_byte_t d;
    regRead(a, d);
    nTests++;
    if (d !== exp) begin
      numErrors++;
      $display("BAD %0t read %h gave %h, expected %h", $time, a, d, exp);
    end
  endtask

  // Polls the control register until a force bit has cleared itself
  task automatic forceWait(input int idx);
    alc_byte_t d;
    int k;
    k = 0;
    d = 8'hff;
    while (d[idx] !== 1'b0 && k < 100) begin
      regRead(`ALC_ADDR_CTL, d);
      k++;
    end
    nTests++;
    if (d[idx] !== 1'b0) begin
      numErrors++;
      $display("BAD %0t force bit %0d never cleared", $time, idx);
    end
  endtask

  // Cycles between two conversion starts of one channel
  task automatic measure(input logic sec, output int n);
    int k;
    k = 0;
    n = 0;
    while (!(sec ? secondConvStart : mainConvStart) && k < 6000) begin
      @(negedge mclk);
      k++;
    end
    @(negedge mclk);
    n = 1;
    while (!(sec ? secondConvStart : mainConvStart) && n < 6000) begin
      @(negedge mclk);
      n++;
    end
  endtask

  task automatic printVerdict;
    $display("Checks %0d, errors %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    repeat (60000) @(posedge mclk);
    numErrors++;
    $display("BAD %0t watchdog expired", $time);
    printVerdict();
  end

  // ==========================================================
  // Test sequence
  initial begin
    int n;
    alc_main_sensor_filter_time_t fm;
    alc_main_sensor_filter_time_t fs;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rdCheck(`ALC_ADDR_CTL, 8'h00);
    rdCheck(`ALC_ADDR_MAIN_EN, 8'h00);
    rdCheck(`ALC_ADDR_SECOND_EN, 8'h00);
    rdCheck(`ALC_ADDR_MAIN_STAT, 8'h00);
    rdCheck(8'h55, 8'h00);
    regWrite(`ALC_ADDR_MAIN_EN, 8'hff);
    rdCheck(`ALC_ADDR_MAIN_EN, 8'h0f);
    regWrite(`ALC_ADDR_SECOND_EN, 8'ha5);
    rdCheck(`ALC_ADDR_SECOND_EN, 8'h05);
    nTests++;
    if (secondAutoLevelEnable !== 4'h5) begin
      numErrors++;
      $display("BAD %0t auto level enable wrong", $time);
    end
    regWrite(`ALC_ADDR_MAIN_STAT, 8'hff);
    rdCheck(`ALC_ADDR_MAIN_STAT, 8'h00);
    // Forced conversions with the backlight off
    regWrite(`ALC_ADDR_CTL, 8'h01);
    forceWait(0);
    rdCheck(`ALC_ADDR_MAIN_STAT, 8'h0c);
    nTests++;
    if (mainLevelTrip !== 4'hc) begin
      numErrors++;
      $display("BAD %0t main trips wrong", $time);
    end
    regWrite(`ALC_ADDR_CTL, 8'h10);
    forceWait(4);
    rdCheck(`ALC_ADDR_SECOND_STAT, 8'h05);
    nTests++;
    if (secondLevelTrip !== 4'h5) begin
      numErrors++;
      $display("BAD %0t second trips wrong", $time);
    end
    regWrite(`ALC_ADDR_MAIN_EN, 8'h04);
    repeat (2) @(posedge mclk);
    rdCheck(`ALC_ADDR_MAIN_STAT, 8'h04);
    // Backlight on: force bits dropped, periodic filter timing
    @(posedge mclk);
    backlightOn <= 1'b1;
    regWrite(`ALC_ADDR_CTL, 8'h11);
    rdCheck(`ALC_ADDR_CTL, 8'h00);
    for (int c = 0; c < 8; c++) begin
      fm = 3'(c);
      fs = 3'(7 - c);
      regWrite(`ALC_ADDR_CTL, {fs, 1'b0, fm, 1'b0});
      rdCheck(`ALC_ADDR_CTL, {fs, 1'b0, fm, 1'b0});
      measure(1'b0, n);
      nTests++;
      if (n != (BASE << c)) begin
        numErrors++;
        $display("BAD %0t main period %0d, code %0d", $time, n, c);
      end
      measure(1'b1, n);
      nTests++;
      if (n != (BASE << (7 - c))) begin
        numErrors++;
        $display("BAD %0t second period %0d, code %0d", $time, n, 7 - c);
      end
    end
    printVerdict();
  end
endmodule // alc_top_tb
